// ---- hw/debug_handshake_step.sv ----
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - completed command gives 16-cycle low plus speedup
// - handshake off, access takes bus at once
// - access waits one core cycle after decode
// - late access sets no-response, keeps going
// - initiated access still completes later
// - step runs one instruction, back to debug
// - pending interrupt: stacking counts as step
// - peripherals freeze only in active debug
// - stop step gives long acknowledge, stop flag
// - interrupt leaves stop into active debug
// - wait step sets flags, long ack, leaves debug
// - wait accepts accesses, interrupt returns, no ack
module debug_handshake_step (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq,
  // single-wire link
  input  wire logic        debug_serial_clock,
  input  wire logic        background_pin_in,
  output logic             background_pin_out,
  output logic             background_pin_oe,
  // decoded host commands
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_kind,
  // internal bus access
  output logic             bus_req,
  output logic             bus_priority,
  input  wire logic        bus_grant,
  input  wire logic        bus_done,
  // processor control
  input  wire logic        irq_pending,
  input  wire logic        wake_irq,
  input  wire logic        cpu_step_done,
  input  wire logic        cpu_exec_stop,
  input  wire logic        cpu_exec_wait,
  output logic             cpu_halt,
  output logic             cpu_step,
  output logic             cpu_stack,
  output logic             cpu_enter_isr,
  output logic             periph_freeze,
  output logic             debug_active_flag
);

  typedef struct packed {
    dbg_hs_pkg::dbg_state_t st;
    logic                   hs_en;
    logic                   stop_ack_en;
    logic                   no_resp;
    logic                   stop_f;
    logic                   wait_f;
    logic [3:0]             ev_stat;
    logic [3:0]             ev_en;
    logic                   acc_wait;
    logic                   acc_req;
    logic                   acc_busy;
    logic                   step_p;
    logic                   stack_p;
    logic                   isr_p;
    logic                   ack_start;
    logic                   ack_long;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } core_t;

  core_t s_reg;
  core_t s_next;

  logic [1:0] lnk_level;
  logic [1:0] lnk_rise;
  logic [1:0] lnk_fall;
  logic       ack_busy;
  logic       retrieve;
  logic       acc_pending;

  // serial clock and pin pass two flops before use
  link_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .raw_in   ({background_pin_in, debug_serial_clock}),
    .level    (lnk_level),
    .rise     (lnk_rise),
    .fall     (lnk_fall)
  );

  // acknowledge pulse on the background pin
  ack_pulse_gen u_ack (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .sclk_rise (lnk_rise[0]),
    .start     (s_reg.ack_start),
    .long_sel  (s_reg.ack_long),
    .pin_out   (background_pin_out),
    .pin_oe    (background_pin_oe),
    .busy      (ack_busy)
  );

  // host pulls the pin low to start data retrieval
  assign acc_pending = s_reg.acc_wait | s_reg.acc_req | s_reg.acc_busy;
  assign retrieve    = lnk_fall[1] & ~background_pin_oe & ~ack_busy;

  // register read mux
  function automatic logic [31:0] read_word(input core_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      dbg_hs_pkg::REG_CTRL: begin
        w[dbg_hs_pkg::CTRL_HS_EN_BIT]    = s.hs_en;
        w[dbg_hs_pkg::CTRL_STOP_ACK_BIT] = s.stop_ack_en;
      end
      dbg_hs_pkg::REG_STATUS: begin
        w[dbg_hs_pkg::STAT_DBG_ACT_BIT] = (s.st != dbg_hs_pkg::ST_RUN) && (s.st != dbg_hs_pkg::ST_WAIT);
        w[dbg_hs_pkg::STAT_NO_RESPONSE_FLAG_BIT]  = s.no_resp;
        w[dbg_hs_pkg::STAT_STOP_BIT]    = s.stop_f;
        w[dbg_hs_pkg::STAT_WAIT_BIT]    = s.wait_f;
        w[dbg_hs_pkg::STAT_STATE_LSB +: 3] = s.st;
      end
      dbg_hs_pkg::REG_IRQ_STAT: w[dbg_hs_pkg::EV_WIDTH-1:0] = s.ev_stat;
      dbg_hs_pkg::REG_IRQ_EN:   w[dbg_hs_pkg::EV_WIDTH-1:0] = s.ev_en;
      default:                  w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a == dbg_hs_pkg::REG_CTRL) || (a == dbg_hs_pkg::REG_STATUS) ||
           (a == dbg_hs_pkg::REG_IRQ_STAT) || (a == dbg_hs_pkg::REG_IRQ_CLR) ||
           (a == dbg_hs_pkg::REG_IRQ_EN);
  endfunction

  // next state: bus slave, access path, stepping, flags
  always_comb begin
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic [3:0] flag_clr;
    logic       do_write;
    logic       ack_now;
    logic       ack_long_now;
    ev_set       = 4'h0;
    ev_clr       = 4'h0;
    flag_clr     = 4'h0;
    do_write     = 1'b0;
    ack_now      = 1'b0;
    ack_long_now = 1'b0;
    s_next           = s_reg;
    s_next.step_p    = 1'b0;
    s_next.stack_p   = 1'b0;
    s_next.isr_p     = 1'b0;
    s_next.ack_start = 1'b0;
    s_next.ack_long  = 1'b0;

    // write channel: address and data in either order, answer after both
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = addr_ok(s_reg.awaddr) ? dbg_hs_pkg::RESP_OKAY : dbg_hs_pkg::RESP_SLVERR;
      do_write      = s_reg.wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (do_write) begin
      unique case (s_reg.awaddr)
        dbg_hs_pkg::REG_CTRL: begin
          s_next.hs_en       = s_reg.wdata[dbg_hs_pkg::CTRL_HS_EN_BIT];
          s_next.stop_ack_en = s_reg.wdata[dbg_hs_pkg::CTRL_STOP_ACK_BIT];
        end
        dbg_hs_pkg::REG_STATUS:  flag_clr = s_reg.wdata[3:0];
        dbg_hs_pkg::REG_IRQ_CLR: ev_clr   = s_reg.wdata[dbg_hs_pkg::EV_WIDTH-1:0];
        dbg_hs_pkg::REG_IRQ_EN:  s_next.ev_en = s_reg.wdata[dbg_hs_pkg::EV_WIDTH-1:0];
        default: ;
      endcase
    end

    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = read_word(s_reg, s_axi_araddr);
      s_next.rresp  = addr_ok(s_axi_araddr) ? dbg_hs_pkg::RESP_OKAY : dbg_hs_pkg::RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    // flag clears first, sets below win
    if (flag_clr[dbg_hs_pkg::STAT_NO_RESPONSE_FLAG_BIT]) s_next.no_resp = 1'b0;
    if (flag_clr[dbg_hs_pkg::STAT_STOP_BIT])   s_next.stop_f  = 1'b0;
    if (flag_clr[dbg_hs_pkg::STAT_WAIT_BIT])   s_next.wait_f  = 1'b0;

    // internal access: one cycle of wait, then request
    if (s_reg.acc_wait) begin
      s_next.acc_wait = 1'b0;
      s_next.acc_req  = 1'b1;
    end
    if (s_reg.acc_req && (bus_grant || !s_reg.hs_en)) begin
      s_next.acc_req  = 1'b0;
      s_next.acc_busy = 1'b1;
    end
    if (s_reg.acc_busy && bus_done) begin
      s_next.acc_busy = 1'b0;
      ack_now         = s_reg.hs_en;
    end
    if (retrieve && acc_pending && !(s_reg.acc_busy && bus_done)) begin
      s_next.no_resp = 1'b1;
      ev_set[dbg_hs_pkg::EV_NO_RESPONSE_FLAG_BIT] = 1'b1;
    end

    // commands and stepping
    unique case (s_reg.st)
      dbg_hs_pkg::ST_RUN: begin
        if (cmd_valid && cmd_kind == dbg_hs_pkg::CMD_HALT) begin
          s_next.st = dbg_hs_pkg::ST_DEBUG;
          ack_now   = s_reg.hs_en;
        end
      end
      dbg_hs_pkg::ST_DEBUG: begin
        if (cmd_valid && cmd_kind == dbg_hs_pkg::CMD_STEP) begin
          s_next.st = dbg_hs_pkg::ST_STEP;
          if (irq_pending) begin
            s_next.stack_p = 1'b1;
          end else begin
            s_next.step_p = 1'b1;
          end
        end else if (cmd_valid && cmd_kind == dbg_hs_pkg::CMD_GO) begin
          s_next.st = dbg_hs_pkg::ST_RUN;
          ack_now   = s_reg.hs_en;
        end else if (cmd_valid && cmd_kind == dbg_hs_pkg::CMD_CONTROL) begin
          ack_now = s_reg.hs_en;
        end
      end
      dbg_hs_pkg::ST_STEP: begin
        if (cpu_exec_stop) begin
          s_next.st = dbg_hs_pkg::ST_STOP;
          if (s_reg.hs_en && s_reg.stop_ack_en) begin
            s_next.stop_f = 1'b1;
            ack_now       = 1'b1;
            ack_long_now  = 1'b1;
            ev_set[dbg_hs_pkg::EV_STOP_BIT] = 1'b1;
          end
        end else if (cpu_exec_wait) begin
          s_next.st      = dbg_hs_pkg::ST_WAIT;
          s_next.wait_f  = 1'b1;
          s_next.no_resp = 1'b1;
          ack_now        = s_reg.hs_en;
          ack_long_now   = 1'b1;
          ev_set[dbg_hs_pkg::EV_WAIT_BIT]   = 1'b1;
          ev_set[dbg_hs_pkg::EV_NO_RESPONSE_FLAG_BIT] = 1'b1;
        end else if (cpu_step_done) begin
          s_next.st = dbg_hs_pkg::ST_DEBUG;
          ack_now   = s_reg.hs_en;
        end
      end
      dbg_hs_pkg::ST_STOP: begin
        if (wake_irq) begin
          s_next.st    = dbg_hs_pkg::ST_DEBUG;
          s_next.isr_p = 1'b1;
        end
      end
      dbg_hs_pkg::ST_WAIT: begin
        if (wake_irq) begin
          s_next.st    = dbg_hs_pkg::ST_DEBUG;
          s_next.isr_p = 1'b1;
        end
      end
      default: s_next.st = dbg_hs_pkg::ST_RUN;
    endcase

    // accesses are non-intrusive, taken in any state while the path is idle
    if (cmd_valid && !acc_pending &&
        (cmd_kind == dbg_hs_pkg::CMD_READ || cmd_kind == dbg_hs_pkg::CMD_WRITE)) begin
      s_next.acc_wait = 1'b1;
    end

    // acknowledge request, dropped if one is still on the pin
    if (ack_now && !ack_busy) begin
      s_next.ack_start = 1'b1;
      s_next.ack_long  = ack_long_now;
      ev_set[dbg_hs_pkg::EV_ACK_BIT] = 1'b1;
    end
    s_next.ev_stat = (s_reg.ev_stat & ~ev_clr) | ev_set;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg             <= '0;
      s_reg.st          <= dbg_hs_pkg::ST_RUN;
      s_reg.hs_en       <= dbg_hs_pkg::HS_EN_RESET;
      s_reg.stop_ack_en <= dbg_hs_pkg::STOP_ACK_RESET;
      s_reg.ev_en       <= dbg_hs_pkg::EV_EN_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // bus slave handshakes
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign irq           = |(s_reg.ev_stat & s_reg.ev_en);

  // core-facing outputs
  assign bus_req           = s_reg.acc_req;
  assign bus_priority      = s_reg.acc_req && !s_reg.hs_en;
  assign cpu_halt          = (s_reg.st == dbg_hs_pkg::ST_DEBUG);
  assign cpu_step          = s_reg.step_p;
  assign cpu_stack         = s_reg.stack_p;
  assign cpu_enter_isr     = s_reg.isr_p;
  assign periph_freeze     = (s_reg.st == dbg_hs_pkg::ST_DEBUG);
  assign debug_active_flag = (s_reg.st != dbg_hs_pkg::ST_RUN) && (s_reg.st != dbg_hs_pkg::ST_WAIT);

  acc_delay_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cmd_valid && !acc_pending && cmd_kind == dbg_hs_pkg::CMD_READ) |=> !bus_req ##1 bus_req)
    else $error("access requested without one cycle of wait");

  bus_priority_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_reg.acc_req && !s_reg.hs_en) |=> s_reg.acc_busy && !bus_req)
    else $error("access waited for a free cycle with handshake off");

  no_response_flag_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (retrieve && acc_pending && !(s_reg.acc_busy && bus_done)) |=> s_reg.no_resp && acc_pending)
    else $error("late access not flagged or aborted");

  step_one_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cpu_halt && cmd_valid && cmd_kind == dbg_hs_pkg::CMD_STEP && !irq_pending)
      |=> cpu_step && !cpu_stack ##1 !cpu_step)
    else $error("step did not issue exactly one instruction");

  step_stack_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cpu_halt && cmd_valid && cmd_kind == dbg_hs_pkg::CMD_STEP && irq_pending) |=> cpu_stack && !cpu_step)
    else $error("pending interrupt step did not stack");

  step_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cpu_step || cpu_stack) |-> !periph_freeze && debug_active_flag)
    else $error("peripherals frozen while stepping");

  stop_long_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_reg.st == dbg_hs_pkg::ST_STEP && cpu_exec_stop && s_reg.hs_en && s_reg.stop_ack_en && !ack_busy)
      |=> s_reg.stop_f && s_reg.ack_start && s_reg.ack_long)
    else $error("stop step without long acknowledge");

  stop_wake_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_reg.st == dbg_hs_pkg::ST_STOP && wake_irq) |=> cpu_halt && cpu_enter_isr)
    else $error("stop exit did not return to debug");

  wait_enter_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_reg.st == dbg_hs_pkg::ST_STEP && !cpu_exec_stop && cpu_exec_wait)
      |=> s_reg.wait_f && s_reg.no_resp && !debug_active_flag)
    else $error("wait step flags wrong");

  wait_wake_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_reg.st == dbg_hs_pkg::ST_WAIT && wake_irq) |=> cpu_halt && cpu_enter_isr && !s_reg.ack_start)
    else $error("wait exit wrong or acknowledged");

endmodule // debug_handshake_step

// ---- hw/dbg_hs_pkg.sv ----
package dbg_hs_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] REG_IRQ_EN   = 8'h10;

  // control field positions and reset values
  localparam int         CTRL_HS_EN_BIT    = 0;
  localparam int         CTRL_STOP_ACK_BIT = 1;
  localparam logic       HS_EN_RESET       = 1'b0;
  localparam logic       STOP_ACK_RESET    = 1'b0;

  // status field positions
  localparam int         STAT_DBG_ACT_BIT  = 0;
  localparam int         STAT_NO_RESPONSE_FLAG_BIT   = 1;
  localparam int         STAT_STOP_BIT     = 2;
  localparam int         STAT_WAIT_BIT     = 3;
  localparam int         STAT_STATE_LSB    = 4;

  // event bits, shared by irq status, clear and enable
  localparam int         EV_ACK_BIT        = 0;
  localparam int         EV_NO_RESPONSE_FLAG_BIT     = 1;
  localparam int         EV_STOP_BIT       = 2;
  localparam int         EV_WAIT_BIT       = 3;
  localparam int         EV_WIDTH          = 4;
  localparam logic [3:0] EV_EN_RESET       = 4'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  // acknowledge timing, in serial clock cycles and core cycles
  localparam logic [6:0] ACK_LOW_CYCLES      = 7'h10;
  localparam logic [6:0] LONG_ACK_CYCLES     = 7'h40;
  localparam logic [1:0] SPEEDUP_CORE_CYCLES = 2'h2;

  // decoded host commands
  typedef enum logic [2:0] {
    CMD_READ    = 3'b000,
    CMD_WRITE   = 3'b001,
    CMD_CONTROL = 3'b010,
    CMD_STEP    = 3'b011,
    CMD_GO      = 3'b100,
    CMD_HALT    = 3'b101
  } dbg_cmd_t;

  // core debug states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_DEBUG = 3'b001,
    ST_STEP  = 3'b010,
    ST_STOP  = 3'b011,
    ST_WAIT  = 3'b100
  } dbg_state_t;

endpackage

// ---- hw/link_sync.sv ----
`timescale 1ns/1ps
module link_sync (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // raw pin levels
  input  wire logic [1:0] raw_in,
  // synchronised levels and edges
  output logic      [1:0] level,
  output logic      [1:0] rise,
  output logic      [1:0] fall
);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  // two flops per bit, third only for edge finding
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = raw_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // edges from the second and third stage only
  assign level = s_reg.s2;
  assign rise  = s_reg.s2 & ~s_reg.s3;
  assign fall  = ~s_reg.s2 & s_reg.s3;

endmodule // link_sync

// ---- hw/ack_pulse_gen.sv ----
`timescale 1ns/1ps
module ack_pulse_gen (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // serial clock edge, one core cycle
  input  wire logic sclk_rise,
  // request
  input  wire logic start,
  input  wire logic long_sel,
  // pin drive
  output logic      pin_out,
  output logic      pin_oe,
  output logic      busy
);

  typedef struct packed {
    logic       active;
    logic       speed;
    logic [6:0] cnt;
    logic [6:0] len;
    logic [1:0] sp;
    logic       oe;
    logic       val;
  } ack_t;

  ack_t s_reg;
  ack_t s_next;

  // low phase counted in serial clock rises, then a driven-high speedup
  always_comb begin
    s_next = s_reg;
    if (!s_reg.active) begin
      if (start) begin
        s_next.active = 1'b1;
        s_next.speed  = 1'b0;
        s_next.cnt    = 7'h00;
        s_next.oe     = 1'b1;
        s_next.val    = 1'b0;
        s_next.len    = long_sel ? dbg_hs_pkg::LONG_ACK_CYCLES - 7'h01
                                 : dbg_hs_pkg::ACK_LOW_CYCLES - 7'h01;
      end
    end else if (!s_reg.speed) begin
      if (sclk_rise) begin
        if (s_reg.cnt == s_reg.len) begin
          s_next.speed = 1'b1;
          s_next.val   = 1'b1;
          s_next.sp    = 2'h0;
        end else begin
          s_next.cnt = s_reg.cnt + 7'h01;
        end
      end
    end else begin
      if (s_reg.sp == dbg_hs_pkg::SPEEDUP_CORE_CYCLES - 2'h1) begin
        s_next.active = 1'b0;
        s_next.speed  = 1'b0;
        s_next.oe     = 1'b0;
        s_next.val    = 1'b0;
      end else begin
        s_next.sp = s_reg.sp + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin_out = s_reg.val;
  assign pin_oe  = s_reg.oe;
  assign busy    = s_reg.active;

  ack_low_end_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(s_reg.speed) |-> $past(sclk_rise) && ($past(s_reg.cnt) == $past(s_reg.len)))
    else $error("ack low phase ended on wrong count");

  ack_speedup_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(s_reg.speed) |-> (pin_oe && pin_out) [*2] ##1 !pin_oe)
    else $error("speedup pulse not two driven-high cycles");

endmodule // ack_pulse_gen

// ---- tb/host_link_model.sv ----
`timescale 1ns/1ps
// host end of the single-wire link
module host_link_model (
  // bench control
  input  wire logic run,
  input  wire logic retrieve,
  // target drive
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // link
  output logic      sclk,
  output logic      pin_level,
  output int        low_rises
);
  // serial clock runs only inside a frame, 125 ns period
  initial begin
    sclk = 1'b0;
    forever #62.5 sclk = run ? ~sclk : 1'b0;
  end
  // pull-up, host pulls low to start retrieval whenever retrieve is set and the target is not driving
  assign pin_level = pin_oe ? pin_out : ~retrieve;
  // low part of each acknowledge, in serial clocks
  initial low_rises = 0;
  always @(posedge sclk) if (pin_oe && !pin_out) low_rises <= low_rises + 1;
endmodule // host_link_model

// ---- tb/test_debug_handshake_step.sv ----
`timescale 1ns/1ps
module test_debug_handshake_step;
  logic        core_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_valid, run, retrieve;
  logic        debug_serial_clock, background_pin_in, background_pin_out, background_pin_oe, bus_req, bus_priority;
  logic        cpu_halt, cpu_step, cpu_stack, cpu_enter_isr, periph_freeze, debug_active_flag, early;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  cmd_kind, seen;
  logic [6:0]  ev;
  int          low_rises, fail_count, check_count, n, base;
  // ev: 0 irq pending, 1 wake, 2 step done, 3 stop, 4 wait, 5 bus done, 6 bus grant
  debug_handshake_step u_dut (.*, .s_axi_wstrb(4'hf), .bus_grant(ev[6]), .bus_done(ev[5]), .irq_pending(ev[0]),
    .wake_irq(ev[1]), .cpu_step_done(ev[2]), .cpu_exec_stop(ev[3]), .cpu_exec_wait(ev[4]));
  host_link_model u_host (.run(run), .retrieve(retrieve), .pin_out(background_pin_out), .pin_oe(background_pin_oe),
    .sclk(debug_serial_clock), .pin_level(background_pin_in), .low_rises(low_rises));
  // core clock and sticky record of processor pulses
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) seen <= seen | {cpu_enter_isr, cpu_stack, cpu_step};
  task test_done;
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bounded clock step
  task tick;
    @(posedge core_clk);
    n++;
    if (n > 3000) begin
      fail_count++;
      test_done;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    n = 0;
    do begin
      tick;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    n = 0;
    do begin
      tick;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task cmd(input logic [2:0] k, input logic [6:0] m);
    @(negedge core_clk);
    seen = '0;
    @(posedge core_clk);
    {cmd_valid, cmd_kind, ev} <= {1'b1, k, m};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    // bus request level in the cycle right after the decode edge
    @(negedge core_clk);
    early = bus_req;
    @(posedge core_clk);
    ev <= '0;
  endtask
  task pulse(input logic [6:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= '0;
  endtask
  // measure the low part of an acknowledge; 0 when none appears
  task ack(input int e);
    n = 0;
    while (!background_pin_oe && n < 20) tick;
    base = low_rises;
    // serial clock only runs while an acknowledge is on the pin
    if (background_pin_oe) begin
      run <= 1'b1;
      while (background_pin_oe) tick;
      run <= 1'b0;
    end
    chk(32'(low_rises - base), 32'(e));
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmd_valid, run, retrieve} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd_kind, ev, rst_b, seen, fail_count, check_count} = '0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, unmapped and write-only places
    rd(dbg_hs_pkg::REG_CTRL, 32'h0, 2'h0);
    rd(dbg_hs_pkg::REG_IRQ_EN, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    rd(dbg_hs_pkg::REG_IRQ_CLR, 32'h0, 2'h0);
    // handshake off: access waits a cycle, then takes the bus with priority
    cmd(dbg_hs_pkg::CMD_READ, 7'h0);
    chk(32'(early), 32'h0);
    @(negedge core_clk);
    chk(32'({bus_req, bus_priority}), 32'h3);
    pulse(7'h20);
    ack(0);
    // handshake on, host retrieves too early
    wr(dbg_hs_pkg::REG_CTRL, 32'h3, 2'h0);
    cmd(dbg_hs_pkg::CMD_READ, 7'h0);
    retrieve <= 1'b1;
    repeat (4) @(posedge core_clk);
    retrieve <= 1'b0;
    @(negedge core_clk);
    chk(32'({bus_req, bus_priority}), 32'h2);
    pulse(7'h40);
    pulse(7'h20);
    ack(16);
    rd(dbg_hs_pkg::REG_STATUS, 32'h2, 2'h0);
    cmd(dbg_hs_pkg::CMD_HALT, 7'h0);
    ack(16);
    chk(32'({debug_active_flag, periph_freeze, cpu_halt}), 32'h7);
    cmd(dbg_hs_pkg::CMD_CONTROL, 7'h0);
    ack(16);
    // plain step, then step over a pending interrupt
    cmd(dbg_hs_pkg::CMD_STEP, 7'h0);
    chk(32'(periph_freeze), 32'h0);
    pulse(7'h04);
    ack(16);
    chk(32'(seen), 32'h1);
    cmd(dbg_hs_pkg::CMD_STEP, 7'h01);
    pulse(7'h04);
    ack(16);
    chk(32'(seen), 32'h2);
    // step over stop, woken by an interrupt
    cmd(dbg_hs_pkg::CMD_STEP, 7'h0);
    pulse(7'h08);
    ack(64);
    rd(dbg_hs_pkg::REG_STATUS, 32'h37, 2'h0);
    pulse(7'h02);
    ack(0);
    chk(32'(seen), 32'h5);
    rd(dbg_hs_pkg::REG_STATUS, 32'h17, 2'h0);
    wr(dbg_hs_pkg::REG_STATUS, 32'he, 2'h0);
    // step over wait, access while waiting, interrupt returns silently
    cmd(dbg_hs_pkg::CMD_STEP, 7'h0);
    pulse(7'h10);
    ack(64);
    rd(dbg_hs_pkg::REG_STATUS, 32'h4a, 2'h0);
    cmd(dbg_hs_pkg::CMD_READ, 7'h0);
    pulse(7'h40);
    pulse(7'h20);
    ack(16);
    pulse(7'h02);
    ack(0);
    chk(32'({seen, debug_active_flag}), 32'h9);
    // interrupt raise, mask, clear
    rd(dbg_hs_pkg::REG_IRQ_STAT, 32'hf, 2'h0);
    wr(dbg_hs_pkg::REG_IRQ_EN, 32'h4, 2'h0);
    chk(32'(irq), 32'h1);
    wr(dbg_hs_pkg::REG_IRQ_CLR, 32'h4, 2'h0);
    @(negedge core_clk);
    chk(32'(irq), 32'h0);
    rd(dbg_hs_pkg::REG_IRQ_STAT, 32'hb, 2'h0);
    cmd(dbg_hs_pkg::CMD_GO, 7'h0);
    ack(16);
    test_done;
  end
endmodule // test_debug_handshake_step
